// ---- ttc_dev.sv ----
// timer/counter unit: three 16-bit counters behind four byte ports
//
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "ttc_defines.svh"
module ttc_dev import ttc_pkg::*; #(
   parameter logic [1:0] UNIT_ID = 2'h0
) (
   input  wire logic       clk,
   input  wire logic       rst_n,
   ttc_if.dev              io,
   input  wire logic [2:0] cnt_clk_pin,
   input  wire logic [2:0] gate_pin,
   output logic      [2:0] cnt_out
);
   // ----------------------------------------------------------------
   // decimal decrement, digit by digit
   // ----------------------------------------------------------------
   function automatic logic [15:0] bcd_dec(input logic [15:0] v);
      logic [15:0] r;
      logic        borrow;
      r      = v;
      borrow = 1'b1;
      for (int d = 0; d < 4; d++) begin
         if (borrow) begin
            if (v[4*d +: 4] == 4'h0) begin
               r[4*d +: 4] = 4'h9;
            end else begin
               r[4*d +: 4] = v[4*d +: 4] - 4'h1;
               borrow      = 1'b0;
            end
         end
      end
      return r;
   endfunction : bcd_dec

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [5:0] pin_s1_q;
   logic [5:0] pin_s2_q;
   logic [5:0] pin_s3_q;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
         pin_s3_q <= '0;
      end else begin
         pin_s1_q <= {gate_pin, cnt_clk_pin};
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   wire       sel      = io.cs && (io.unit == UNIT_ID);
   wire       wr_ctl   = sel && io.wr && (io.addr == `TTC_PORT_CTL);
   wire [1:0] ctl_cnt  = io.wdata[`TTC_SEL_HI:`TTC_SEL_LO];
   wire [1:0] ctl_fmt  = io.wdata[`TTC_FMT_HI:`TTC_FMT_LO];
   wire [2:0] ctl_m    = io.wdata[`TTC_MODE_HI:`TTC_MODE_LO];
   // modes 6 and 7 drop the top bit and run as modes 2 and 3
   wire [2:0] ctl_mode = ctl_m[1] ? {1'b0, ctl_m[1:0]} : ctl_m;
   wire [7:0] rd_byte [3];

   // ----------------------------------------------------------------
   // counters
   // ----------------------------------------------------------------
   for (genvar i = 0; i < 3; i++) begin : g_cnt
      ttc_mode_t   mode_q;
      logic        bcd_q;
      logic [1:0]  fmt_q;
      logic [15:0] cnt_q;
      logic [15:0] reload_q;
      logic [15:0] latch_q;
      logic        latched_q;
      logic        wsecond_q;
      logic        rsecond_q;
      logic [7:0]  lsb_q;
      logic        armed_q;
      logic        run_q;
      logic        out_q;

      wire        hit      = sel && (io.addr == 2'(i));
      wire        ctl_me   = wr_ctl && (ctl_cnt == 2'(i));
      wire        latch_cmd = ctl_me && (ctl_fmt == `TTC_FMT_LATCH);
      wire        prog     = ctl_me && (ctl_fmt != `TTC_FMT_LATCH);
      wire        dwr      = hit && io.wr;
      wire        drd      = hit && io.rd;
      wire        two      = (fmt_q == `TTC_FMT_BOTH);
      wire        load_now = dwr && (!two || wsecond_q);
      wire [15:0] ld_val   = (fmt_q == `TTC_FMT_LOW)  ? {8'h00, io.wdata} :
                             (fmt_q == `TTC_FMT_HIGH) ? {io.wdata, 8'h00} :
                             {io.wdata, lsb_q};
      wire        tick     = pin_s2_q[i] && !pin_s3_q[i];
      wire        g_lvl    = pin_s2_q[i+3];
      wire        g_rise   = pin_s2_q[i+3] && !pin_s3_q[i+3];
      wire        hw_trig  = (mode_q == TTC_M_ONESHOT) || (mode_q == TTC_M_HWSTROBE);
      // binary wraps through FFFF, decimal through 9999
      wire [15:0] dec1     = bcd_q ? bcd_dec(cnt_q) : cnt_q - `TTC_CNT_ONE;
      wire [15:0] dec2     = bcd_q ? bcd_dec(bcd_dec(cnt_q)) : cnt_q - `TTC_CNT_TWO;
      wire        at_one   = (cnt_q == `TTC_CNT_ONE);
      wire        low_end  = (cnt_q <= `TTC_CNT_TWO);
      wire        count_en = tick && run_q && (hw_trig || g_lvl);
      wire [15:0] src      = latched_q ? latch_q : cnt_q;
      wire        r_hi     = (fmt_q == `TTC_FMT_HIGH) || (two && rsecond_q);
      wire        r_last   = !two || rsecond_q;

      assign rd_byte[i] = r_hi ? src[15:8] : src[7:0];
      assign cnt_out[i] = out_q;

      always_ff @(posedge clk) begin
         if (!rst_n) begin
            mode_q    <= TTC_M_TERMINAL;
            bcd_q     <= 1'b0;
            fmt_q     <= `TTC_FMT_LOW;
            cnt_q     <= '0;
            reload_q  <= '0;
            latch_q   <= '0;
            latched_q <= 1'b0;
            wsecond_q <= 1'b0;
            rsecond_q <= 1'b0;
            lsb_q     <= '0;
            armed_q   <= 1'b0;
            run_q     <= 1'b0;
            out_q     <= 1'b1;
         end else if (prog) begin
            mode_q    <= ttc_mode_t'(ctl_mode);
            bcd_q     <= io.wdata[`TTC_BCD_BIT];
            fmt_q     <= ctl_fmt;
            wsecond_q <= 1'b0;
            rsecond_q <= 1'b0;
            latched_q <= 1'b0;
            armed_q   <= 1'b0;
            run_q     <= 1'b0;
            out_q     <= (ctl_mode != TTC_M_TERMINAL);
         end else begin
            // a second latch command is ignored until the snapshot is read
            if (latch_cmd && !latched_q) begin
               latch_q   <= cnt_q;
               latched_q <= 1'b1;
            end
            if (drd) begin
               rsecond_q <= two && !rsecond_q;
               if (r_last) begin
                  latched_q <= 1'b0;
               end
            end
            if (dwr && two && !wsecond_q) begin
               lsb_q     <= io.wdata;
               wsecond_q <= 1'b1;
            end
            if (load_now) begin
               wsecond_q <= 1'b0;
               reload_q  <= ld_val;
               armed_q   <= 1'b1;
               if (!hw_trig) begin
                  cnt_q <= ld_val;
                  run_q <= 1'b1;
               end
               if (mode_q == TTC_M_TERMINAL) begin
                  out_q <= 1'b0;
               end
            end else if (hw_trig && armed_q && g_rise) begin
               cnt_q <= reload_q;
               run_q <= 1'b1;
               out_q <= (mode_q == TTC_M_HWSTROBE);
            end else if (count_en) begin
               case (mode_q)
                  TTC_M_TERMINAL, TTC_M_ONESHOT: begin
                     cnt_q <= dec1;
                     if (at_one) begin
                        out_q <= 1'b1;
                     end
                  end
                  TTC_M_RATE: begin
                     cnt_q <= at_one ? reload_q : dec1;
                     out_q <= (cnt_q != `TTC_CNT_TWO);
                  end
                  TTC_M_SQUARE: begin
                     cnt_q <= low_end ? reload_q : dec2;
                     if (low_end) begin
                        out_q <= !out_q;
                     end
                  end
                  TTC_M_SWSTROBE, TTC_M_HWSTROBE: begin
                     cnt_q <= dec1;
                     out_q <= !at_one;
                  end
                  default: begin
                     cnt_q <= dec1;
                  end
               endcase
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------
   logic [7:0] rdata_q;
   wire        rd_hit = sel && io.rd;
   wire [7:0]  rd_mux = (io.addr == `TTC_PORT_CTL) ? 8'h00 : rd_byte[io.addr];
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata_q <= '0;
      end else if (rd_hit) begin
         rdata_q <= rd_mux;
      end
   end
   assign io.rdata = rdata_q;
endmodule : ttc_dev

// ---- ttc_defines.svh ----
// constants for the three-channel timer/counter and its controller
`ifndef TTC_DEFINES_SVH
`define TTC_DEFINES_SVH
`define TTC_PORT_CTL      2'h3
`define TTC_SEL_HI        7
`define TTC_SEL_LO        6
`define TTC_FMT_HI        5
`define TTC_FMT_LO        4
`define TTC_MODE_HI       3
`define TTC_MODE_LO       1
`define TTC_BCD_BIT       0
`define TTC_SEL_ILLEGAL   2'h3
`define TTC_FMT_LATCH     2'h0
`define TTC_FMT_LOW       2'h1
`define TTC_FMT_HIGH      2'h2
`define TTC_FMT_BOTH      2'h3
`define TTC_CNT_ONE       16'h0001
`define TTC_CNT_TWO       16'h0002
`define TTC_REG_CMD       5'h00
`define TTC_REG_STATUS    5'h04
`define TTC_REG_IRQ_STAT  5'h08
`define TTC_REG_IRQ_MASK  5'h0C
`define TTC_REG_UNIT      5'h10
`define TTC_CMD_PORT_HI   9
`define TTC_CMD_PORT_LO   8
`define TTC_CMD_RD_BIT    10
`define TTC_IRQ_DONE      0
`define TTC_IRQ_REFUSED   1
`define TTC_ST_BUSY       0
`define TTC_ST_BYTE_LO    8
`define TTC_ST_BYTE_HI    15
`endif

// ---- ttc_pkg.sv ----
// types shared by the timer/counter and its controller
package ttc_pkg;
   typedef enum logic [2:0] {
      TTC_M_TERMINAL = 3'b000,
      TTC_M_ONESHOT  = 3'b001,
      TTC_M_RATE     = 3'b010,
      TTC_M_SQUARE   = 3'b011,
      TTC_M_SWSTROBE = 3'b100,
      TTC_M_HWSTROBE = 3'b101
   } ttc_mode_t;
   typedef enum logic [1:0] {
      TTC_H_IDLE   = 2'b00,
      TTC_H_STROBE = 2'b01,
      TTC_H_CAPT   = 2'b10
   } ttc_hstate_t;
endpackage : ttc_pkg

// ---- ttc_if.sv ----
// byte-wide i/o bus between the controller and one timer/counter unit
`timescale 1ns/1ns
interface ttc_if;
   logic       cs;
   logic [1:0] unit;
   logic [1:0] addr;
   logic       wr;
   logic       rd;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport dev  (input cs, unit, addr, wr, rd, wdata, output rdata);
   modport host (output cs, unit, addr, wr, rd, wdata, input rdata);
endinterface : ttc_if

// ---- ttc_host.sv ----
// controller end: avalon-mm command registers driving the byte bus
`timescale 1ns/1ns
`include "ttc_defines.svh"
module ttc_host import ttc_pkg::*; (
   input  wire logic        clk,
   input  wire logic        rst_n,
   ttc_if.host              io,
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   output logic             irq
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   ttc_hstate_t st_q;
   logic [1:0]  port_q;
   logic [7:0]  byte_q;
   logic        is_rd_q;
   logic [7:0]  rbyte_q;
   logic [2:0]  cfg_q;
   logic [1:0]  unit_q;
   logic [1:0]  irq_st_q;
   logic [1:0]  irq_mask_q;
   logic [31:0] rdata_q;
   logic        rvalid_q;

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   wire        busy    = (st_q != TTC_H_IDLE);
   wire        wr_cmd  = avs_write && (avs_address == `TTC_REG_CMD);
   wire        wr_unit = avs_write && (avs_address == `TTC_REG_UNIT);
   wire        wr_stat = avs_write && (avs_address == `TTC_REG_IRQ_STAT);
   wire        wr_mask = avs_write && (avs_address == `TTC_REG_IRQ_MASK);
   wire [1:0]  c_port  = avs_writedata[`TTC_CMD_PORT_HI:`TTC_CMD_PORT_LO];
   wire        c_rd    = avs_writedata[`TTC_CMD_RD_BIT];
   wire [7:0]  c_byte  = avs_writedata[7:0];
   wire [1:0]  c_sel   = c_byte[`TTC_SEL_HI:`TTC_SEL_LO];
   wire        c_ctl   = (c_port == `TTC_PORT_CTL);
   // illegal select and counters whose number no control word has named yet, in any unit, never reach the bus
   wire        refuse  = c_ctl ? (c_rd || c_sel == `TTC_SEL_ILLEGAL) :
                                 !cfg_q[c_port];
   wire        take    = wr_cmd && !busy;
   wire        done    = (st_q == TTC_H_CAPT);
   wire [1:0]  ev      = {take && refuse, done};
   wire [31:0] rd_mux  =
      (avs_address == `TTC_REG_STATUS)   ? {16'h0000, rbyte_q, 7'h00, busy} :
      (avs_address == `TTC_REG_IRQ_STAT) ? {30'h0, irq_st_q} :
      (avs_address == `TTC_REG_IRQ_MASK) ? {30'h0, irq_mask_q} :
      (avs_address == `TTC_REG_UNIT)     ? {30'h0, unit_q} : 32'h0000_0000;

   assign avs_waitrequest = (wr_cmd && busy) || (avs_read && !rvalid_q);
   assign avs_readdata    = rdata_q;
   assign irq             = |(irq_st_q & irq_mask_q);

   // ----------------------------------------------------------------
   // bus drive
   // ----------------------------------------------------------------
   wire strobe = (st_q == TTC_H_STROBE);
   assign io.cs    = strobe;
   assign io.unit  = unit_q;
   assign io.addr  = port_q;
   assign io.wr    = strobe && !is_rd_q;
   assign io.rd    = strobe && is_rd_q;
   assign io.wdata = byte_q;

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_q    <= TTC_H_IDLE;
         port_q  <= '0;
         byte_q  <= '0;
         is_rd_q <= 1'b0;
         rbyte_q <= '0;
         cfg_q   <= '0;
      end else begin
         case (st_q)
            TTC_H_IDLE: begin
               if (take && !refuse) begin
                  port_q  <= c_port;
                  byte_q  <= c_byte;
                  is_rd_q <= c_rd;
                  st_q    <= TTC_H_STROBE;
                  if (c_ctl) begin
                     cfg_q[c_sel] <= 1'b1;
                  end
               end
            end
            TTC_H_STROBE: begin
               st_q <= TTC_H_CAPT;
            end
            TTC_H_CAPT: begin
               if (is_rd_q) begin
                  rbyte_q <= io.rdata;
               end
               st_q <= TTC_H_IDLE;
            end
            default: begin
               st_q <= TTC_H_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // registers and interrupts
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         unit_q     <= '0;
         irq_st_q   <= '0;
         irq_mask_q <= '0;
         rdata_q    <= '0;
         rvalid_q   <= 1'b0;
      end else begin
         rvalid_q <= avs_read && !rvalid_q;
         if (avs_read && !rvalid_q) begin
            rdata_q <= rd_mux;
         end
         if (wr_unit && !busy) begin
            unit_q <= avs_writedata[1:0];
         end
         if (wr_mask) begin
            irq_mask_q <= avs_writedata[1:0];
         end
         // a new event beats a clear in the same cycle
         irq_st_q <= (irq_st_q & ~(wr_stat ? avs_writedata[1:0] : 2'b00)) | ev;
      end
   end
endmodule : ttc_host

// ---- ttc_assertions.sv ----
// bus-side checks between the controller and one timer/counter unit
`timescale 1ns/1ns
module ttc_assertions import ttc_pkg::*; #(
   parameter logic [1:0] UNIT_ID = 2'h0
) (
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       cs,
   input wire logic [1:0] unit,
   input wire logic [1:0] addr,
   input wire logic       wr,
   input wire logic       rd,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ----------------------------------------
   // strobe shape
   // ----------------------------------------
   a_strobe_single: assert property (cs |=> (!cs) [*2])
      else $error("strobe too long or too close");
   a_strobe_kind: assert property (cs |-> (wr ^ rd))
      else $error("strobe without exactly one direction");
   a_strobe_qualified: assert property ((wr || rd) |-> cs)
      else $error("direction strobe without select");
   a_reset_quiet: assert property ($rose(rst_n) |-> !cs && rdata == 8'h00)
      else $error("bus not quiet after reset");
   // ----------------------------------------
   // control port and read data
   // ----------------------------------------
   a_ctl_write_only: assert property ((cs && addr == 2'h3) |-> wr)
      else $error("control port read on the bus");
   a_select_legal: assert property ((cs && wr && addr == 2'h3) |-> wdata[7:6] != 2'h3)
      else $error("illegal counter select sent");
   a_rdata_cause: assert property (!$stable(rdata) |-> $past(cs && rd && unit == UNIT_ID))
      else $error("read byte changed without a read");
   a_rdata_hold: assert property ((cs && rd && unit == UNIT_ID) |=> ##1 $stable(rdata))
      else $error("read byte not held");
endmodule : ttc_assertions

// ---- three_channel_timer_counter_bench.sv ----
// self-checking bench for the timer/counter unit and its controller
`timescale 1ns/1ns
`include "ttc_defines.svh"
module three_channel_timer_counter_bench import ttc_pkg::*; ;
   logic        clk;
   logic        rst_n;
   logic [4:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        irq;
   logic [2:0]  cnt_clk_pin;
   logic [2:0]  gate_pin;
   logic [2:0]  cnt_out;
   logic [31:0] s;
   int          fail_count;
   int          total_checks;

   ttc_if bus_if ();
   ttc_dev #(.UNIT_ID(2'h0)) ttc_dev_inst (.clk(clk), .rst_n(rst_n), .io(bus_if),
      .cnt_clk_pin(cnt_clk_pin), .gate_pin(gate_pin), .cnt_out(cnt_out));
   ttc_host ttc_host_inst (.clk(clk), .rst_n(rst_n), .io(bus_if),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .irq(irq));
   ttc_assertions #(.UNIT_ID(2'h0)) ttc_assertions_inst (.clk(clk), .rst_n(rst_n),
      .cs(bus_if.cs), .unit(bus_if.unit), .addr(bus_if.addr), .wr(bus_if.wr),
      .rd(bus_if.rd), .wdata(bus_if.wdata), .rdata(bus_if.rdata));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : complete_run

   task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         $display("Error %s expected %0h seen %0h", n, e, g);
         fail_count++;
      end
   endtask : check

   // request stands until the edge that sees waitrequest low; data taken there
   task automatic av_cycle(input logic [4:0] a, input logic w, input logic [31:0] d,
                           output logic [31:0] q);
      int n;
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= w;
      avs_read      <= !w;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      q = avs_readdata;
      if (avs_waitrequest !== 1'b0) begin
         fail_count++;
         complete_run();
      end
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      // one idle edge so the next call never re-drives a strobe in this step
      @(posedge clk);
   endtask : av_cycle

   task automatic reg_wr(input logic [4:0] a, input logic [31:0] d);
      av_cycle(a, 1'b1, d, s);
   endtask : reg_wr

   task automatic reg_chk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
      av_cycle(a, 1'b0, 32'h0, s);
      check("register", e, s & m);
   endtask : reg_chk

   task automatic put(input logic [1:0] p, input logic [7:0] b, input logic rdb);
      int n;
      av_cycle(`TTC_REG_CMD, 1'b1, {21'h0, rdb, p, b}, s);
      n = 0;
      do begin
         av_cycle(`TTC_REG_STATUS, 1'b0, 32'h0, s);
         n++;
      end while (s[`TTC_ST_BUSY] !== 1'b0 && n < 20);
      check("busy", 32'h0, {31'h0, s[`TTC_ST_BUSY]});
      if (s[`TTC_ST_BUSY] !== 1'b0) begin
         complete_run();
      end
   endtask : put

   task automatic get(input logic [1:0] p, input logic [7:0] e);
      put(p, 8'h00, 1'b1);
      check("read byte", {24'h0, e}, {24'h0, s[`TTC_ST_BYTE_HI:`TTC_ST_BYTE_LO]});
   endtask : get

   // outputs are looked at mid-cycle, away from the launching edge
   task automatic pin_chk(input logic sel, input logic e);
      @(negedge clk);
      check(sel ? "cnt_out2" : "irq", 32'(e), {31'h0, (sel ? cnt_out[2] : irq)});
      @(posedge clk);
   endtask : pin_chk

   // count clock kept well below half the system clock
   task automatic pulse(input int n);
      repeat (n) begin
         cnt_clk_pin[2] <= 1'b1;
         repeat (4) @(posedge clk);
         cnt_clk_pin[2] <= 1'b0;
         repeat (4) @(posedge clk);
      end
   endtask : pulse

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      rst_n = 1'b0;
      avs_address = 5'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      cnt_clk_pin = 3'h0;
      gate_pin = 3'h7;
      fail_count = 0;
      total_checks = 0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      reg_chk(5'h14, 32'hFFFFFFFF, 32'h0);
      reg_wr(`TTC_REG_IRQ_MASK, 32'h3);
      reg_chk(`TTC_REG_IRQ_MASK, 32'h3, 32'h3);
      put(2'h0, 8'h11, 1'b0);
      reg_chk(`TTC_REG_IRQ_STAT, 32'h2, 32'h2);
      pin_chk(1'b0, 1'b1);
      reg_wr(`TTC_REG_IRQ_STAT, 32'h3);
      reg_chk(`TTC_REG_IRQ_STAT, 32'h2, 32'h0);
      pin_chk(1'b0, 1'b0);
      reg_wr(`TTC_REG_IRQ_MASK, 32'h0);
      put(2'h3, 8'hC0, 1'b0);
      reg_chk(`TTC_REG_IRQ_STAT, 32'h2, 32'h2);
      pin_chk(1'b0, 1'b0);
      reg_wr(`TTC_REG_IRQ_STAT, 32'h3);
      put(2'h3, 8'h00, 1'b1);
      reg_chk(`TTC_REG_IRQ_STAT, 32'h2, 32'h2);
      reg_wr(`TTC_REG_IRQ_STAT, 32'h3);
      reg_wr(`TTC_REG_IRQ_MASK, 32'h1);
      put(2'h3, 8'h30, 1'b0);
      pin_chk(1'b0, 1'b1);
      reg_wr(`TTC_REG_IRQ_STAT, 32'h1);
      pin_chk(1'b0, 1'b0);
      reg_wr(`TTC_REG_IRQ_MASK, 32'h0);
      put(2'h0, 8'h77, 1'b0);
      put(2'h3, 8'h30, 1'b0);
      put(2'h0, 8'h34, 1'b0);
      put(2'h0, 8'h12, 1'b0);
      reg_wr(`TTC_REG_UNIT, 32'h1);
      put(2'h3, 8'h30, 1'b0);
      put(2'h0, 8'hFF, 1'b0);
      put(2'h0, 8'hFF, 1'b0);
      reg_wr(`TTC_REG_UNIT, 32'h0);
      put(2'h3, 8'h00, 1'b0);
      get(2'h0, 8'h34);
      get(2'h0, 8'h12);
      pin_chk(1'b1, 1'b1);
      for (int m = 0; m < 8; m++) begin
         put(2'h3, {4'h7, m[2:0], 1'b0}, 1'b0);
         put(2'h1, {5'h00, m[2:0]}, 1'b0);
         put(2'h1, {5'h14, m[2:0]}, 1'b0);
         // one-shot and hardware strobe load the count only on a gate rise
         gate_pin[1] <= 1'b0;
         repeat (4) @(posedge clk);
         gate_pin[1] <= 1'b1;
         repeat (4) @(posedge clk);
         put(2'h3, 8'h40, 1'b0);
         get(2'h1, {5'h00, m[2:0]});
         get(2'h1, {5'h14, m[2:0]});
      end
      put(2'h3, 8'h50, 1'b0);
      put(2'h1, 8'hAB, 1'b0);
      put(2'h3, 8'h40, 1'b0);
      get(2'h1, 8'hAB);
      put(2'h3, 8'h60, 1'b0);
      put(2'h1, 8'h56, 1'b0);
      put(2'h3, 8'h40, 1'b0);
      get(2'h1, 8'h56);
      @(negedge clk);
      check("cnt_out1to0", 32'h0, {30'h0, cnt_out[1:0]});
      @(posedge clk);
      put(2'h3, 8'hB0, 1'b0);
      put(2'h2, 8'h05, 1'b0);
      put(2'h2, 8'h00, 1'b0);
      pulse(2);
      put(2'h3, 8'h80, 1'b0);
      pulse(2);
      get(2'h2, 8'h03);
      get(2'h2, 8'h00);
      pin_chk(1'b1, 1'b0);
      pulse(1);
      pin_chk(1'b1, 1'b1);
      for (int b = 1; b >= 0; b--) begin
         put(2'h3, {7'h58, b[0]}, 1'b0);
         put(2'h2, 8'h00, 1'b0);
         put(2'h2, 8'h00, 1'b0);
         pulse(1);
         put(2'h3, 8'h80, 1'b0);
         get(2'h2, b[0] ? 8'h99 : 8'hFF);
         get(2'h2, b[0] ? 8'h99 : 8'hFF);
      end
      complete_run();
   end
endmodule : three_channel_timer_counter_bench
